// ### ptic_pkg.sv
// Constants shared by the paired timer and input capture block
package ptic_pkg;
    localparam int          ADDR_W       = 5;
    localparam int          DATA_W       = 16;
    localparam int          FIFO_DEPTH   = 4;
    localparam int          DMA_CH       = 2;
    localparam logic [4:0]  OFF_LO_CTL   = 5'h00;
    localparam logic [4:0]  OFF_UP_CTL   = 5'h01;
    localparam logic [4:0]  OFF_LO_CNT   = 5'h02;
    localparam logic [4:0]  OFF_UP_CNT   = 5'h03;
    localparam logic [4:0]  OFF_CAP_BASE = 5'h10;
    localparam int          B_ON         = 15;
    localparam int          B_SIDL       = 13;
    localparam int          B_GATE       = 6;
    localparam int          B_PSH        = 5;
    localparam int          B_PSL        = 4;
    localparam int          B_PAIR       = 3;
    localparam int          B_TCS        = 1;
    localparam int          B_CSIDL      = 13;
    localparam int          B_CTMR       = 7;
    localparam int          B_CIH        = 6;
    localparam int          B_CIL        = 5;
    localparam int          B_COV        = 4;
    localparam int          B_CBNE       = 3;
    localparam logic [15:0] LO_CTL_MASK  = 16'hA07A;
    localparam logic [15:0] UP_CTL_MASK  = 16'hA072;
    localparam logic [15:0] CAP_WR_MASK  = 16'h20E7;
    localparam logic [15:0] RESET_VAL    = 16'h0000;
    localparam logic [2:0]  CM_OFF       = 3'h0;
    localparam logic [2:0]  CM_EDGE      = 3'h1;
    localparam logic [2:0]  CM_FALL      = 3'h2;
    localparam logic [2:0]  CM_RISE      = 3'h3;
    localparam logic [2:0]  CM_R4        = 3'h4;
    localparam logic [2:0]  CM_R16       = 3'h5;
    localparam logic [2:0]  CM_WAKE      = 3'h7;
    localparam logic [7:0]  PS_1         = 8'h00;
    localparam logic [7:0]  PS_8         = 8'h07;
    localparam logic [7:0]  PS_64        = 8'h3F;
    localparam logic [7:0]  PS_256       = 8'hFF;
    localparam logic [3:0]  CAP_DIV4     = 4'h3;
    localparam logic [3:0]  CAP_DIV16    = 4'hF;
endpackage

// ### ptic_top.sv
// Paired 16/32-bit timers with input capture channels
`timescale 1ns/1ns

// Functional notes
// - Pair mode: lower on bit runs 32-bit timer
// - Unpaired: each on bit runs own timer
// - Timer idle-halt bit stops it in Idle
// - Gate accumulation only with internal clock
// - Prescale 00/01/10/11 gives 1/8/64/256
// - Pair-mode bit joins timers into 32 bits
// - Clock source 1 counts external pin rises
// - Paired: upper control bits ignored except its idle-halt bit
// - Unimplemented bits read zero, ignore writes
// - Capture event latches selected timer count
// - Mode field picks edge kind or off
// - Mode 111: rising-edge wake/interrupt in Sleep/Idle
// - Every-edge mode ignores captures-per-interrupt
// - Interrupt after 1, 2, 3 or 4 captures
// - Four-word capture FIFO per channel
// - Buffer-not-empty reads 1 while data unread
// - Overflow flag sticky, cleared only by turning channel off
// - Timebase select 1 second, 0 third timer
// - Capture idle-halt stops channel captures in Idle; wake mode ignores it
// - Only first two channels request DMA
module ptic_top #(
    parameter int NCH = 8
) (
    input  wire logic                      mclk_in,
    input  wire logic                      rst_in,
    input  wire logic [ptic_pkg::ADDR_W-1:0] addr_in,
    input  wire logic [ptic_pkg::DATA_W-1:0] wr_data_in,
    input  wire logic                      wr_en_in,
    input  wire logic                      rd_en_in,
    output logic      [ptic_pkg::DATA_W-1:0] rd_data_out,
    input  wire logic                      idle_in,
    input  wire logic                      sleep_in,
    input  wire logic                      lower_ext_clock_pin_in,
    input  wire logic                      upper_ext_clock_pin_in,
    input  wire logic                      lower_gate_in,
    input  wire logic                      upper_gate_in,
    input  wire logic [NCH-1:0]            capture_input_pin_in,
    output logic      [NCH-1:0]            cap_irq_out,
    output logic      [ptic_pkg::DMA_CH-1:0] dma_req_out,
    output logic                           wake_out
);
    import ptic_pkg::*;

    function automatic logic [7:0] tmr_limit(input logic [15:0] ctl);
        case (ctl[B_PSH:B_PSL])
            2'h3:    tmr_limit = PS_256;
            2'h2:    tmr_limit = PS_64;
            2'h1:    tmr_limit = PS_8;
            default: tmr_limit = PS_1;
        endcase
    endfunction

    function automatic logic [4:0] cap_ctl_addr(input int c);
        cap_ctl_addr = 5'(int'(OFF_CAP_BASE) + 2 * c);
    endfunction

    function automatic logic [4:0] cap_buf_addr(input int c);
        cap_buf_addr = 5'(int'(OFF_CAP_BASE) + 2 * c + 1);
    endfunction

    // Timers: index 0 is the lower (second) timer, 1 the upper (third)
    logic [15:0] ctl_q   [2];
    logic [15:0] cnt_q   [2];
    logic [7:0]  psc_q   [2];
    logic [1:0]  epin_prev_q;

    wire         pair    = ctl_q[0][B_PAIR];
    wire  [1:0]  epin    = {upper_ext_clock_pin_in, lower_ext_clock_pin_in};
    wire  [1:0]  gate    = {upper_gate_in, lower_gate_in};
    wire         ctl_wr0 = wr_en_in && addr_in == OFF_LO_CTL;
    wire         ctl_wr1 = wr_en_in && addr_in == OFF_UP_CTL;
    wire         cnt_wr0 = wr_en_in && addr_in == OFF_LO_CNT;
    wire         cnt_wr1 = wr_en_in && addr_in == OFF_UP_CNT;
    wire         lo_wrap = cnt_q[0] == 16'hFFFF;

    logic [15:0] ectl    [2];
    logic [1:0]  src_tick;
    logic [1:0]  halt;
    logic [1:0]  run;
    logic [1:0]  psc_end;

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_tmr
            // Paired upper takes every setting except its idle-halt bit from the lower control
            assign ectl[gi]     = pair ? ctl_q[0] : ctl_q[gi];
            // External clock counts rising edges; gate only on internal
            assign src_tick[gi] = ectl[gi][B_TCS] ?
                                  (epin[pair ? 0 : gi] && !epin_prev_q[pair ? 0 : gi]) :
                                  (!ectl[gi][B_GATE] || gate[pair ? 0 : gi]);
            // Paired halt honours both idle-halt bits
            assign halt[gi]     = idle_in && (ctl_q[gi][B_SIDL] ||
                                  (pair && ctl_q[1 - gi][B_SIDL]));
            assign run[gi]      = ectl[gi][B_ON] && !halt[gi];
            assign psc_end[gi]  = psc_q[gi] == tmr_limit(ectl[gi]);
        end
    endgenerate

    wire inc_lo = run[0] && src_tick[0] && psc_end[0];
    wire inc_up = pair ? (inc_lo && lo_wrap) : (run[1] && src_tick[1] && psc_end[1]);

    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            ctl_q[0]    <= RESET_VAL;
            ctl_q[1]    <= RESET_VAL;
            cnt_q[0]    <= RESET_VAL;
            cnt_q[1]    <= RESET_VAL;
            psc_q[0]    <= 8'h00;
            psc_q[1]    <= 8'h00;
            epin_prev_q <= 2'h0;
        end
        else
        begin
            epin_prev_q <= epin;
            if (ctl_wr0)
            begin
                ctl_q[0] <= wr_data_in & LO_CTL_MASK;
            end
            if (ctl_wr1)
            begin
                ctl_q[1] <= wr_data_in & UP_CTL_MASK;
            end
            for (int i = 0; i < 2; i++)
            begin
                // A control write restarts the prescaler phase
                if ((i == 0 && ctl_wr0) || (i == 1 && ctl_wr1))
                begin
                    psc_q[i] <= 8'h00;
                end
                else if (run[i] && src_tick[i])
                begin
                    psc_q[i] <= psc_end[i] ? 8'h00 : psc_q[i] + 8'h01;
                end
            end
            // A count write wins over a tick in the same cycle
            if (cnt_wr0)
            begin
                cnt_q[0] <= wr_data_in;
            end
            else if (inc_lo)
            begin
                cnt_q[0] <= cnt_q[0] + 16'h0001;
            end
            // Upper word carries from the lower when paired
            if (cnt_wr1)
            begin
                cnt_q[1] <= wr_data_in;
            end
            else if (inc_up)
            begin
                cnt_q[1] <= cnt_q[1] + 16'h0001;
            end
        end
    end

    // Capture channels
    logic [15:0] cctl_q  [NCH];

    // Fill level reaches four, so it needs one bit more than the pointers
    logic [15:0] fifo_q  [NCH][FIFO_DEPTH];
    logic [1:0]  wp_q    [NCH];
    logic [1:0]  rp_q    [NCH];
    logic [2:0]  fill_q  [NCH];

    // Edge prescaler and captures-per-interrupt counters
    logic [3:0]  pre_q   [NCH];
    logic [1:0]  icnt_q  [NCH];

    logic [NCH-1:0] ov_q;
    logic [NCH-1:0] pin_prev_q;
    logic [NCH-1:0] irq_q;
    logic [DMA_CH-1:0] dma_q;
    logic        wake_q;
    logic [15:0] rd_q;

    logic [NCH-1:0] rise;
    logic [NCH-1:0] fall;
    logic [NCH-1:0] cap_ev;
    logic [NCH-1:0] push;
    logic [NCH-1:0] ovset;
    logic [NCH-1:0] pop;
    logic [NCH-1:0] cwr;
    logic [NCH-1:0] wake_ev;
    logic [NCH-1:0] irq_ev;
    logic [15:0]    tval [NCH];
    logic [15:0]    cread [NCH];

    generate
        for (gi = 0; gi < NCH; gi++)
        begin : g_cap
            wire [2:0] mode   = cctl_q[gi][2:0];
            wire       active = !(idle_in && cctl_q[gi][B_CSIDL]);
            wire       full   = fill_q[gi] == 3'(FIFO_DEPTH);
            wire       p4     = pre_q[gi][1:0] == CAP_DIV4[1:0];
            wire       p16    = pre_q[gi] == CAP_DIV16;
            logic      ev_raw;
            // A pin already high out of reset counts as one rising edge
            assign rise[gi] = capture_input_pin_in[gi] && !pin_prev_q[gi];
            assign fall[gi] = !capture_input_pin_in[gi] && pin_prev_q[gi];
            always_comb
            begin
                case (mode)
                    CM_EDGE: ev_raw = rise[gi] || fall[gi];
                    CM_FALL: ev_raw = fall[gi];
                    CM_RISE: ev_raw = rise[gi];
                    CM_R4:   ev_raw = rise[gi] && p4;
                    CM_R16:  ev_raw = rise[gi] && p16;
                    default: ev_raw = 1'b0;
                endcase
            end
            assign cap_ev[gi]  = active && ev_raw;
            assign tval[gi]    = cctl_q[gi][B_CTMR] ? cnt_q[0] : cnt_q[1];
            assign cwr[gi]     = wr_en_in && addr_in == cap_ctl_addr(gi);
            assign pop[gi]     = rd_en_in && addr_in == cap_buf_addr(gi) &&
                                 fill_q[gi] != 3'h0;
            assign push[gi]    = cap_ev[gi] && !full;
            // Full buffer keeps old words; the new value is lost
            assign ovset[gi]   = cap_ev[gi] && full;
            // Wake mode ignores every other control bit
            assign wake_ev[gi] = mode == CM_WAKE && (sleep_in || idle_in) &&
                                 rise[gi];
            assign irq_ev[gi]  = wake_ev[gi] || (cap_ev[gi] &&
                                 (mode == CM_EDGE ||
                                  icnt_q[gi] == cctl_q[gi][B_CIH:B_CIL]));
            assign cread[gi]   = {cctl_q[gi][15:5], ov_q[gi],
                                  fill_q[gi] != 3'h0, cctl_q[gi][2:0]};
        end
    endgenerate

    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            for (int c = 0; c < NCH; c++)
            begin
                cctl_q[c] <= RESET_VAL;
                wp_q[c]   <= 2'h0;
                rp_q[c]   <= 2'h0;
                fill_q[c] <= 3'h0;
                pre_q[c]  <= 4'h0;
                icnt_q[c] <= 2'h0;
                for (int k = 0; k < FIFO_DEPTH; k++)
                begin
                    fifo_q[c][k] <= RESET_VAL;
                end
            end
            ov_q       <= '0;
            pin_prev_q <= '0;
            irq_q      <= '0;
            dma_q      <= '0;
            wake_q     <= 1'b0;
        end
        else
        begin
            pin_prev_q <= capture_input_pin_in;
            irq_q      <= irq_ev;
            wake_q     <= |wake_ev;
            // DMA requests exist only on the first channels
            dma_q      <= push[DMA_CH-1:0];
            for (int c = 0; c < NCH; c++)
            begin
                if (cwr[c])
                begin
                    cctl_q[c] <= wr_data_in & CAP_WR_MASK;
                end
                // Turning a channel off flushes it; only path to clear overflow
                if (cwr[c] && wr_data_in[2:0] == CM_OFF)
                begin
                    // An overflow in the clearing cycle still wins
                    ov_q[c]   <= ovset[c];
                    fill_q[c] <= 3'h0;
                    wp_q[c]   <= 2'h0;
                    rp_q[c]   <= 2'h0;
                    pre_q[c]  <= 4'h0;
                    icnt_q[c] <= 2'h0;
                end
                else
                begin
                    if (ovset[c])
                    begin
                        ov_q[c] <= 1'b1;
                    end
                    if (push[c])
                    begin
                        fifo_q[c][wp_q[c]] <= tval[c];
                        wp_q[c] <= wp_q[c] + 2'h1;
                    end
                    if (pop[c])
                    begin
                        rp_q[c] <= rp_q[c] + 2'h1;
                    end
                    // Push and pop together leave the fill level alone
                    if (push[c] && !pop[c])
                    begin
                        fill_q[c] <= fill_q[c] + 3'h1;
                    end
                    else if (pop[c] && !push[c])
                    begin
                        fill_q[c] <= fill_q[c] - 3'h1;
                    end
                    if (cwr[c])
                    begin
                        pre_q[c] <= 4'h0;
                    end
                    else if (rise[c] && cctl_q[c][2])
                    begin
                        pre_q[c] <= pre_q[c] + 4'h1;
                    end
                    if (cap_ev[c])
                    begin
                        icnt_q[c] <= irq_ev[c] ? 2'h0 : icnt_q[c] + 2'h1;
                    end
                end
            end
        end
    end

    // Read data mux, registered for the next cycle
    logic [15:0] rd_val;
    always_comb
    begin
        rd_val = 16'h0000;
        case (addr_in)
            OFF_LO_CTL: rd_val = ctl_q[0];
            OFF_UP_CTL: rd_val = ctl_q[1];
            OFF_LO_CNT: rd_val = cnt_q[0];
            OFF_UP_CNT: rd_val = cnt_q[1];
            default:    rd_val = 16'h0000;
        endcase
        for (int c = 0; c < NCH; c++)
        begin
            if (addr_in == cap_ctl_addr(c))
            begin
                rd_val = cread[c];
            end
            if (addr_in == cap_buf_addr(c))
            begin
                rd_val = fifo_q[c][rp_q[c]];
            end
        end
    end

    // Read data drops to zero outside the answer cycle
    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            rd_q <= 16'h0000;
        end
        else if (rd_en_in)
        begin
            rd_q <= rd_val;
        end
        else
        begin
            rd_q <= 16'h0000;
        end
    end

    assign rd_data_out = rd_q;
    assign cap_irq_out = irq_q;
    assign dma_req_out = dma_q;
    assign wake_out    = wake_q;
endmodule

// ### ptic_asserts.sv
// Port-level assertions for the paired timer capture block
`timescale 1ns/1ns
module ptic_asserts #(
    parameter int NCH = 8
) (
    input wire logic           mclk_in,
    input wire logic           rst_in,
    input wire logic [4:0]     addr_in,
    input wire logic           rd_en_in,
    input wire logic [15:0]    rd_data_out,
    input wire logic           idle_in,
    input wire logic           sleep_in,
    input wire logic [NCH-1:0] capture_input_pin_in,
    input wire logic [NCH-1:0] cap_irq_out,
    input wire logic [1:0]     dma_req_out,
    input wire logic           wake_out
);
    import ptic_pkg::*;
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (rst_in);
    // Pin sync may add a cycle, so allow two
    sequence pin0_moved_s;
        ($past(capture_input_pin_in[0]) != $past(capture_input_pin_in[0], 2))
            || ($past(capture_input_pin_in[0], 2) != $past(capture_input_pin_in[0], 3));
    endsequence
    sequence any_rose_s;
        (|($past(capture_input_pin_in) & ~$past(capture_input_pin_in, 2)))
            || (|($past(capture_input_pin_in, 2) & ~$past(capture_input_pin_in, 3)));
    endsequence
    read_quiet_a: assert property (!$past(rd_en_in) |-> rd_data_out == 16'h0000)
        else $error("read data not zero outside a read");
    unmapped_zero_a: assert property (rd_en_in && addr_in inside {[5'h04:5'h0F]}
        |=> rd_data_out == 16'h0000)
        else $error("unmapped read not zero");
    lo_ctl_mask_a: assert property (rd_en_in && addr_in == OFF_LO_CTL
        |=> (rd_data_out & ~LO_CTL_MASK) == 16'h0000)
        else $error("lower control unimplemented bit set");
    up_ctl_mask_a: assert property (rd_en_in && addr_in == OFF_UP_CTL
        |=> (rd_data_out & ~UP_CTL_MASK) == 16'h0000)
        else $error("upper control unimplemented bit set");
    cap_ctl_mask_a: assert property (rd_en_in && addr_in[4] && !addr_in[0]
        |=> (rd_data_out & ~(CAP_WR_MASK | 16'h0018)) == 16'h0000)
        else $error("capture control unimplemented bit set");
    irq_cause_a: assert property (cap_irq_out[0] |-> pin0_moved_s)
        else $error("capture interrupt without pin edge");
    dma_cause_a: assert property (dma_req_out[0] |-> pin0_moved_s)
        else $error("dma request without pin edge");
    wake_state_a: assert property (wake_out
        |-> $past(sleep_in || idle_in) || $past(sleep_in || idle_in, 2))
        else $error("wake pulse while running");
    wake_edge_a: assert property (wake_out |-> any_rose_s)
        else $error("wake pulse without rising edge");
endmodule

bind ptic_top ptic_asserts #(.NCH(NCH)) u_asserts (
    .mclk_in(mclk_in), .rst_in(rst_in), .addr_in(addr_in), .rd_en_in(rd_en_in),
    .rd_data_out(rd_data_out), .idle_in(idle_in), .sleep_in(sleep_in),
    .capture_input_pin_in(capture_input_pin_in), .cap_irq_out(cap_irq_out),
    .dma_req_out(dma_req_out), .wake_out(wake_out));

// ### ptic_pins.sv
// Model of the capture pins and external timer clock pins
`timescale 1ns/1ns
module ptic_pins #(
    parameter int NCH = 8
) (
    input  wire logic      clk_in,
    output logic [NCH-1:0] cap_pin_out,
    output logic           lo_clk_out,
    output logic           up_clk_out
);
    initial
    begin
        cap_pin_out = '0;
        lo_clk_out = 1'b0;
        up_clk_out = 1'b0;
    end
    // Each level held long enough for the pin sampler
    task automatic set_pin(input int ch, input logic lvl);
        @(posedge clk_in);
        cap_pin_out[ch] <= lvl;
        repeat (4) @(posedge clk_in);
    endtask
    // Clock pins rest low between bursts
    task automatic ext_pulse(input logic up, input int n);
        repeat (n)
        begin
            @(posedge clk_in);
            if (up) up_clk_out <= 1'b1; else lo_clk_out <= 1'b1;
            repeat (2) @(posedge clk_in);
            if (up) up_clk_out <= 1'b0; else lo_clk_out <= 1'b0;
            repeat (2) @(posedge clk_in);
        end
    endtask
endmodule

// ### ptic_bench.sv
// Self-checking bench for the paired timer capture block
`timescale 1ns/1ns
module ptic_bench;
    import ptic_pkg::*;
    localparam logic [4:0] CTL0 = 5'h10;
    localparam logic [4:0] BUF0 = 5'h11;
    logic        mclk_in = 1'b0;
    logic        rst_in = 1'b1;
    logic [4:0]  addr_in = '0;
    logic [15:0] wr_data_in = '0;
    logic        wr_en_in = 1'b0;
    logic        rd_en_in = 1'b0;
    logic        idle_in = 1'b0;
    logic        sleep_in = 1'b0;
    logic        lo_gate = 1'b0;
    logic        up_gate = 1'b0;
    logic [15:0] rd_data_out;
    logic [7:0]  pins;
    logic [7:0]  irq;
    logic [1:0]  dma;
    logic        lo_ck;
    logic        up_ck;
    logic        wake;
    logic [15:0] v;
    logic [15:0] t0;
    int          bad_count = 0;
    int          comparisons = 0;
    int          irq_n = 0;
    int          dma_n = 0;
    int          dma1_n = 0;
    int          wake_n = 0;
    int          i0;
    int          dv[4] = '{1, 8, 64, 256};
    logic [4:0]  ra[4] = '{OFF_LO_CTL, OFF_UP_CTL, CTL0, 5'h1F};
    logic [15:0] rm[4] = '{LO_CTL_MASK, UP_CTL_MASK, CAP_WR_MASK, 16'h0000};
    ptic_top #(.NCH(8)) u_dut (.mclk_in(mclk_in), .rst_in(rst_in), .addr_in(addr_in),
        .wr_data_in(wr_data_in), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in),
        .rd_data_out(rd_data_out), .idle_in(idle_in), .sleep_in(sleep_in),
        .lower_ext_clock_pin_in(lo_ck), .upper_ext_clock_pin_in(up_ck),
        .lower_gate_in(lo_gate), .upper_gate_in(up_gate), .capture_input_pin_in(pins),
        .cap_irq_out(irq), .dma_req_out(dma), .wake_out(wake));
    ptic_pins #(.NCH(8)) u_pins (.clk_in(mclk_in), .cap_pin_out(pins), .lo_clk_out(lo_ck),
        .up_clk_out(up_ck));
    initial forever #4 mclk_in = ~mclk_in;
    // Sampled mid-cycle, away from the edge that launches the pulses
    always @(negedge mclk_in)
    begin
        irq_n += int'(irq[0] === 1'b1);
        dma_n += int'(dma[0] === 1'b1);
        dma1_n += int'(dma[1] === 1'b1);
        wake_n += int'(wake === 1'b1);
    end
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge mclk_in);
        wr_en_in <= 1'b1;
        addr_in <= a;
        wr_data_in <= d;
        @(posedge mclk_in);
        wr_en_in <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        @(posedge mclk_in);
        rd_en_in <= 1'b1;
        addr_in <= a;
        @(posedge mclk_in);
        rd_en_in <= 1'b0;
        #1 d = rd_data_out;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            bad_count++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic rdchk(input logic [4:0] a, input logic [15:0] exp);
        rd(a, v);
        chk(v, exp);
    endtask
    // Reads sit n+2 cycles apart
    task automatic delta(input logic [4:0] a, input int n, input logic [15:0] exp);
        rd(a, t0);
        repeat (n) @(posedge mclk_in);
        rd(a, v);
        chk(v - t0, exp);
    endtask
    task automatic pulse(input int ch);
        u_pins.set_pin(ch, 1'b1);
        u_pins.set_pin(ch, 1'b0);
    endtask
    task automatic finish_test;
        $display("compares %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge mclk_in);
        bad_count++;
        finish_test();
    end
    initial
    begin
        repeat (20) @(posedge mclk_in);
        rst_in <= 1'b0;
        for (int i = 0; i < 4; i++)
        begin
            rdchk(ra[i], 16'h0000);
            wr(ra[i], 16'hFFFF);
            rdchk(ra[i], rm[i]);
            wr(ra[i], 16'h0000);
        end
        wr(5'h07, 16'hFFFF);
        rdchk(5'h07, 16'h0000);
        $display("register test done");
        for (int i = 0; i < 4; i++)
        begin
            wr(OFF_LO_CTL, 16'h8000 | (16'(i) << 4));
            delta(OFF_LO_CNT, 2 * dv[i] - 2, 16'h0002);
        end
        wr(OFF_LO_CTL, 16'h0000);
        wr(OFF_UP_CTL, 16'h8000);
        delta(OFF_LO_CNT, 14, 16'h0000);
        delta(OFF_UP_CNT, 14, 16'h0010);
        wr(OFF_UP_CTL, 16'hA000);
        @(posedge mclk_in) idle_in <= 1'b1;
        delta(OFF_UP_CNT, 14, 16'h0000);
        wr(OFF_UP_CTL, 16'h8000);
        delta(OFF_UP_CNT, 14, 16'h0010);
        @(posedge mclk_in) idle_in <= 1'b0;
        wr(OFF_UP_CTL, 16'h0030);
        wr(OFF_LO_CTL, 16'h0008);
        wr(OFF_LO_CNT, 16'hFFF0);
        wr(OFF_UP_CNT, 16'h0000);
        wr(OFF_LO_CTL, 16'h8008);
        repeat (30) @(posedge mclk_in);
        rdchk(OFF_UP_CNT, 16'h0001);
        wr(OFF_LO_CTL, 16'h0008);
        delta(OFF_LO_CNT, 14, 16'h0000);
        wr(OFF_LO_CTL, 16'h8042);
        rd(OFF_LO_CNT, t0);
        u_pins.ext_pulse(1'b0, 5);
        rd(OFF_LO_CNT, v);
        chk(v - t0, 16'h0005);
        wr(OFF_LO_CTL, 16'h8040);
        delta(OFF_LO_CNT, 14, 16'h0000);
        @(posedge mclk_in) lo_gate <= 1'b1;
        delta(OFF_LO_CNT, 14, 16'h0010);
        @(posedge mclk_in) lo_gate <= 1'b0;
        wr(OFF_LO_CTL, 16'h0000);
        $display("timer test done");
        wr(CTL0, 16'h0083);
        i0 = irq_n;
        for (int k = 0; k < 5; k++)
        begin
            wr(OFF_LO_CNT, 16'h0100 + 16'(k));
            pulse(0);
            if (k == 3)
                chk(16'(irq_n - i0), 16'h0004);
        end
        chk(16'(dma_n), 16'h0004);
        rdchk(CTL0, 16'h009B);
        for (int k = 0; k < 4; k++)
            rdchk(BUF0, 16'h0100 + 16'(k));
        rdchk(CTL0, 16'h0093);
        wr(CTL0, 16'h0000);
        wr(CTL0, 16'h00E3);
        i0 = irq_n;
        repeat (3) pulse(0);
        chk(16'(irq_n - i0), 16'h0000);
        pulse(0);
        chk(16'(irq_n - i0), 16'h0001);
        wr(CTL0, 16'h0000);
        wr(CTL0, 16'h00E1);
        i0 = irq_n;
        pulse(0);
        chk(16'(irq_n - i0), 16'h0002);
        wr(CTL0, 16'h0000);
        wr(CTL0, 16'h0082);
        wr(OFF_LO_CNT, 16'h1111);
        u_pins.set_pin(0, 1'b1);
        wr(OFF_LO_CNT, 16'h2222);
        u_pins.set_pin(0, 1'b0);
        rdchk(BUF0, 16'h2222);
        rdchk(CTL0, 16'h0082);
        for (int m = 4; m < 6; m++)
        begin
            wr(CTL0, 16'h0000);
            wr(CTL0, 16'h0080 | 16'(m));
            for (int k = 0; k < (m == 4 ? 4 : 16); k++)
            begin
                wr(OFF_LO_CNT, 16'h0300 + 16'(k));
                pulse(0);
            end
            rdchk(BUF0, m == 4 ? 16'h0303 : 16'h030F);
            rdchk(CTL0, 16'h0080 | 16'(m));
        end
        wr(CTL0, 16'h0000);
        wr(OFF_UP_CNT, 16'h5A5A);
        wr(CTL0, 16'h0003);
        pulse(0);
        rdchk(BUF0, 16'h5A5A);
        wr(CTL0, 16'h2083);
        @(posedge mclk_in) idle_in <= 1'b1;
        pulse(0);
        rdchk(CTL0, 16'h2083);
        @(posedge mclk_in) idle_in <= 1'b0;
        wr(CTL0, 16'h0000);
        pulse(0);
        rdchk(CTL0, 16'h0000);
        $display("capture test done");
        wr(5'h12, 16'h0007);
        @(posedge mclk_in) sleep_in <= 1'b1;
        i0 = wake_n;
        pulse(1);
        chk(16'(wake_n - i0), 16'h0001);
        @(posedge mclk_in) sleep_in <= 1'b0;
        pulse(1);
        chk(16'(wake_n - i0), 16'h0001);
        wr(5'h12, 16'h0083);
        pulse(1);
        chk(16'(dma1_n), 16'h0001);
        rdchk(5'h13, 16'h030F);
        $display("wake test done");
        finish_test();
    end
endmodule
